// File: src/modem_ctl_pkg.sv
package modem_ctl_pkg;

  // core clock and documented transition times
  localparam int CLK_PERIOD_NS    = 20;
  localparam int NS_PER_MS        = 1000000;
  localparam int NS_PER_US        = 1000;
  localparam int OFF_IDLE_MIN_MS  = 10;
  localparam int HIB_IDLE_MIN_MS  = 7;
  localparam int DOZE_IDLE_US     = 300;
  localparam int RXTX_WARM_US     = 144;

  // least times round up to whole core cycles
  localparam int OFF_IDLE_CYC  = (OFF_IDLE_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIB_IDLE_CYC  = (HIB_IDLE_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOZE_IDLE_CYC = (DOZE_IDLE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RXTX_WARM_CYC = (RXTX_WARM_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W        = 20;

  // register map, six-bit resource addresses
  localparam int         REG_COUNT        = 64;
  localparam logic [5:0] REG_MODE_STATUS  = 6'h01;
  localparam logic [5:0] REG_MODE_CTL     = 6'h02;
  localparam logic [5:0] REG_DOZE_CMP     = 6'h03;
  localparam logic [5:0] REG_PIN_CFG      = 6'h07;
  localparam logic [5:0] REG_MODEM_CLOCK_OUTPUT_TRIM    = 6'h0A;

  // field positions
  localparam int MODE_REQ_MSB          = 2;
  localparam int MODE_REQ_LSB          = 0;
  localparam int MODE_TIMER_EN_BIT     = 8;
  localparam int PIN_CFG_DOZE_MODEM_CLOCK_OUTPUT_BIT = 9;
  localparam int PIN_CFG_MISO_FLOAT_BIT = 11;
  localparam int TRIM_MSB              = 15;
  localparam int TRIM_LSB              = 8;
  localparam int MODEM_CLOCK_OUTPUT_SEL_MSB          = 2;
  localparam int MODEM_CLOCK_OUTPUT_SEL_LSB          = 0;

  // reset values
  localparam logic [15:0] REG_DEFAULT_RESET  = 16'h0000;
  localparam logic [15:0] PIN_CFG_RESET      = 16'h0800;
  localparam logic [15:0] MODEM_CLOCK_OUTPUT_TRIM_RESET    = 16'h0000;
  localparam logic [11:0] STATUS_PAD         = 12'h000;

  // mode request codes in the mode control field
  localparam logic [2:0] REQ_IDLE      = 3'h0;
  localparam logic [2:0] REQ_HIBERNATE = 3'h1;
  localparam logic [2:0] REQ_DOZE      = 3'h2;
  localparam logic [2:0] REQ_RECEIVE   = 3'h3;
  localparam logic [2:0] REQ_TRANSMIT  = 3'h4;

  // clock output select; 25 MHz >> 5 is the first rate at or below 1 MHz
  localparam logic [2:0] MODEM_CLOCK_OUTPUT_SEL_UNDIVIDED = 3'h0;
  localparam logic [2:0] MODEM_CLOCK_OUTPUT_DOZE_MIN_SEL  = 3'h5;
  localparam logic [7:0] MODEM_CLOCK_OUTPUT_DIV_ONE       = 8'h01;
  localparam logic [8:0] MODEM_CLOCK_OUTPUT_PERIOD_ONE    = 9'h002;

  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [3:0] {
    ST_OFF, ST_HIBERNATE, ST_HIB_WAKE, ST_DOZE, ST_DOZE_WAKE,
    ST_IDLE, ST_RX_WARM, ST_RX, ST_TX_WARM, ST_TX
  } power_state_t;

  typedef struct packed {
    logic       rd;
    logic       spare;
    logic [5:0] addr;
  } spi_header_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } spi_byte_t;

  typedef struct packed {
    logic sclk;
    logic ce_n;
    logic mosi;
  } spi_pins_t;

endpackage : modem_ctl_pkg

// File: src/spi_burst_shifter.sv
`timescale 1ns/1ps
module spi_burst_shifter (
  // clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  // sampled serial pins and gating
  input  modem_ctl_pkg::spi_pins_t     pins_i,
  input  wire logic                    enable_i,
  // next byte to present on miso
  input  wire logic                    load_i,
  input  wire logic [7:0]              load_data_i,
  // received bytes, serial out and frame state
  output modem_ctl_pkg::spi_byte_t     rx_byte_o,
  output logic                         miso_o,
  output logic                         frame_o,
  output logic                         frame_end_o
);

  logic       sclk_q,  sclk_d;
  logic       act_q,   act_d;
  logic [2:0] cnt_q,   cnt_d;
  logic [7:0] shin_q,  shin_d;
  logic [7:0] tx_q,    tx_d;
  logic       miso_q,  miso_d;
  logic       end_q,   end_d;
  modem_ctl_pkg::spi_byte_t rx_q, rx_d;
  logic       rise;
  logic       fall;
  logic [7:0] tx_src;

  // pins are synchronous, so the previous sample is enough for edges
  always_comb
  begin
    act_d  = enable_i & ~pins_i.ce_n;
    sclk_d = pins_i.sclk;
    rise   = act_q & act_d & pins_i.sclk & ~sclk_q;
    fall   = act_q & act_d & ~pins_i.sclk & sclk_q;
    tx_src = load_i ? load_data_i : tx_q;
    cnt_d  = cnt_q;
    shin_d = shin_q;
    tx_d   = tx_src;
    miso_d = miso_q;
    rx_d   = '0;
    end_d  = act_q & ~act_d;
    if (act_d && !act_q)
    begin
      // fresh frame: header phase sends zeros
      cnt_d  = '0;
      tx_d   = '0;
      miso_d = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        shin_d = {shin_q[6:0], pins_i.mosi};
        cnt_d  = 3'(cnt_q + 3'h1);
        if (cnt_q == modem_ctl_pkg::BIT_LAST)
        begin
          rx_d.valid = 1'b1;
          rx_d.data  = {shin_q[6:0], pins_i.mosi};
        end
      end
      if (fall)
      begin
        miso_d = tx_src[7];
        tx_d   = {tx_src[6:0], 1'b0};
      end
    end
  end

  // register only
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sclk_q <= 1'b0;
      act_q  <= 1'b0;
      cnt_q  <= '0;
      shin_q <= '0;
      tx_q   <= '0;
      miso_q <= 1'b0;
      end_q  <= 1'b0;
      rx_q   <= '0;
    end
    else
    begin
      sclk_q <= sclk_d;
      act_q  <= act_d;
      cnt_q  <= cnt_d;
      shin_q <= shin_d;
      tx_q   <= tx_d;
      miso_q <= miso_d;
      end_q  <= end_d;
      rx_q   <= rx_d;
    end
  end

  assign rx_byte_o   = rx_q;
  assign miso_o      = miso_q;
  assign frame_o     = act_q;
  assign frame_end_o = end_q;

endmodule : spi_burst_shifter

// File: src/modem_ctl.sv
// Functional notes
// - reset release leaves Off for Idle; outputs float while reset held
// - hibernate stops oscillator, ignores serial, keeps data, wakes on attention
// - doze keeps oscillator, clock out gated by enable and slow rate, wakes attention/timer
// - idle runs oscillator, drives clock output, accepts serial control
// - hibernate and doze entered only by a register write made in idle
// - transaction framed by low chip enable, at least three bursts
// - clock idles low; sample on rising edge, change on falling edge
// - eight bit bursts, most significant bit first
// - first burst is the header with six-bit address and direction
// - later bursts are write data or read data, never both
// - payload is at least two bytes, longer bursts continue the access
// - shifting is separate; register moves run on the core clock
// - trim byte in bits 15:8 of register 0A warps the oscillator
// - select 000 in register 0A bits 2:0 gives undivided clock out
// - serial out floats when deselected unless float enable bit 11 clear
`timescale 1ns/1ps
module modem_ctl #(
  parameter int OFF_IDLE_CYC  = modem_ctl_pkg::OFF_IDLE_CYC,
  parameter int HIB_IDLE_CYC  = modem_ctl_pkg::HIB_IDLE_CYC,
  parameter int DOZE_IDLE_CYC = modem_ctl_pkg::DOZE_IDLE_CYC,
  parameter int RXTX_WARM_CYC = modem_ctl_pkg::RXTX_WARM_CYC
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // serial slave pins
  input  wire logic        serial_shift_clock_i,
  input  wire logic        ce_n_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // wake and interrupt pins
  input  wire logic        attention_wake_n_i,
  output logic             irq_n_o,
  output logic             irq_oe_o,
  // clock output and oscillator controls
  output logic             modem_clock_output_o,
  output logic             modem_clock_output_oe_o,
  output logic             osc_enable_o,
  output logic [7:0]       xtal_trim_o,
  // radio controls
  output logic             receiver_on_o,
  output logic             transmitter_on_o
);

  localparam logic [modem_ctl_pkg::WAIT_W-1:0] WAIT_OFF  = modem_ctl_pkg::WAIT_W'(OFF_IDLE_CYC - 1);
  localparam logic [modem_ctl_pkg::WAIT_W-1:0] WAIT_HIB  = modem_ctl_pkg::WAIT_W'(HIB_IDLE_CYC - 1);
  localparam logic [modem_ctl_pkg::WAIT_W-1:0] WAIT_DOZE = modem_ctl_pkg::WAIT_W'(DOZE_IDLE_CYC - 1);
  localparam logic [modem_ctl_pkg::WAIT_W-1:0] WAIT_WARM = modem_ctl_pkg::WAIT_W'(RXTX_WARM_CYC - 1);

  modem_ctl_pkg::power_state_t state_q, state_d;
  logic [modem_ctl_pkg::WAIT_W-1:0] wait_q, wait_d;
  logic [15:0] doze_cnt_q, doze_cnt_d;
  logic [15:0] regs_q [modem_ctl_pkg::REG_COUNT];
  logic [15:0] regs_d [modem_ctl_pkg::REG_COUNT];

  modem_ctl_pkg::spi_header_t hdr_q, hdr_d;
  logic        want_hdr_q, want_hdr_d;
  logic        hi_phase_q, hi_phase_d;
  logic [7:0]  hi_byte_q,  hi_byte_d;
  logic [5:0]  addr_q,     addr_d;
  logic        pend_q,     pend_d;
  logic [2:0]  pend_req_q, pend_req_d;
  logic        load_q,     load_d;
  logic [7:0]  load_dat_q, load_dat_d;
  logic        wr_en;
  logic [15:0] wr_data;
  logic [15:0] rd_word;

  logic [7:0]  div_q, div_d;
  logic        modem_clock_output_q, modem_clock_output_d;
  logic        modem_clock_output_oe_q, modem_clock_output_oe_d;
  logic        miso_q, miso_d;
  logic        miso_oe_q, miso_oe_d;
  logic        irq_oe_q, irq_oe_d;
  logic        osc_q, osc_d;
  logic        rx_on_q, rx_on_d;
  logic        tx_on_q, tx_on_d;

  modem_ctl_pkg::spi_pins_t pins;
  modem_ctl_pkg::spi_byte_t rx_byte;
  logic        sh_miso;
  logic        frame;
  logic        frame_end;
  logic        spi_on;
  logic        cmd_fire;
  logic        osc_on;
  logic        modem_clock_output_run;
  logic [2:0]  modem_clock_output_sel;
  logic [7:0]  modem_clock_output_half;
  logic [8:0]  modem_clock_output_period;
  logic        timer_hit;

  // status reads show live state; every other address is storage
  function automatic logic [15:0] read_word(input logic [5:0] a);
    read_word = (a == modem_ctl_pkg::REG_MODE_STATUS) ? {modem_ctl_pkg::STATUS_PAD, state_q} : regs_q[a];
  endfunction : read_word

  function automatic logic [15:0] reset_word(input int a);
    if (a == int'(modem_ctl_pkg::REG_PIN_CFG))
      reset_word = modem_ctl_pkg::PIN_CFG_RESET;
    else if (a == int'(modem_ctl_pkg::REG_MODEM_CLOCK_OUTPUT_TRIM))
      reset_word = modem_ctl_pkg::MODEM_CLOCK_OUTPUT_TRIM_RESET;
    else
      reset_word = modem_ctl_pkg::REG_DEFAULT_RESET;
  endfunction : reset_word

  assign pins = '{sclk: serial_shift_clock_i, ce_n: ce_n_i, mosi: mosi_i};

  // serial port is dead outside the awake states
  assign spi_on = (state_q == modem_ctl_pkg::ST_IDLE) || (state_q == modem_ctl_pkg::ST_RX_WARM) ||
                  (state_q == modem_ctl_pkg::ST_RX) || (state_q == modem_ctl_pkg::ST_TX_WARM) ||
                  (state_q == modem_ctl_pkg::ST_TX);

  spi_burst_shifter u_shifter (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .pins_i      (pins),
    .enable_i    (spi_on),
    .load_i      (load_q),
    .load_data_i (load_dat_q),
    .rx_byte_o   (rx_byte),
    .miso_o      (sh_miso),
    .frame_o     (frame),
    .frame_end_o (frame_end)
  );

  // transaction decode, all on the core clock
  always_comb
  begin
    hdr_d      = hdr_q;
    want_hdr_d = want_hdr_q;
    hi_phase_d = hi_phase_q;
    hi_byte_d  = hi_byte_q;
    addr_d     = addr_q;
    pend_d     = pend_q;
    pend_req_d = pend_req_q;
    load_d     = 1'b0;
    load_dat_d = load_dat_q;
    wr_en      = 1'b0;
    wr_data    = {hi_byte_q, rx_byte.data};
    rd_word    = read_word(addr_q); // a call result cannot be sliced, so stage it here
    if (frame_end)
    begin
      want_hdr_d = 1'b1;
      pend_d     = 1'b0;
    end
    else if (rx_byte.valid)
    begin
      if (want_hdr_q)
      begin
        hdr_d      = rx_byte.data;
        addr_d     = rx_byte.data[5:0];
        want_hdr_d = 1'b0;
        hi_phase_d = 1'b1;
        load_d     = rx_byte.data[7];
        rd_word    = read_word(rx_byte.data[5:0]);
        load_dat_d = rd_word[15:8];
      end
      else if (hdr_q.rd)
      begin
        // read payload: low byte, then next word high byte
        load_d = 1'b1;
        if (hi_phase_q)
        begin
          load_dat_d = rd_word[7:0];
          hi_phase_d = 1'b0;
        end
        else
        begin
          addr_d     = 6'(addr_q + 6'h01);
          rd_word    = read_word(6'(addr_q + 6'h01));
          load_dat_d = rd_word[15:8];
          hi_phase_d = 1'b1;
        end
      end
      else if (hi_phase_q)
      begin
        hi_byte_d  = rx_byte.data;
        hi_phase_d = 1'b0;
      end
      else
      begin
        // a word commits only once both payload bytes arrived
        wr_en      = (addr_q != modem_ctl_pkg::REG_MODE_STATUS);
        addr_d     = 6'(addr_q + 6'h01);
        hi_phase_d = 1'b1;
        if (addr_q == modem_ctl_pkg::REG_MODE_CTL)
        begin
          pend_d     = 1'b1;
          pend_req_d = wr_data[modem_ctl_pkg::MODE_REQ_MSB:modem_ctl_pkg::MODE_REQ_LSB];
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hdr_q      <= '0;
      want_hdr_q <= 1'b1;
      hi_phase_q <= 1'b1;
      hi_byte_q  <= '0;
      addr_q     <= '0;
      pend_q     <= 1'b0;
      pend_req_q <= modem_ctl_pkg::REQ_IDLE;
      load_q     <= 1'b0;
      load_dat_q <= '0;
    end
    else
    begin
      hdr_q      <= hdr_d;
      want_hdr_q <= want_hdr_d;
      hi_phase_q <= hi_phase_d;
      hi_byte_q  <= hi_byte_d;
      addr_q     <= addr_d;
      pend_q     <= pend_d;
      pend_req_q <= pend_req_d;
      load_q     <= load_d;
      load_dat_q <= load_dat_d;
    end
  end

  // register file: contents survive every power mode
  generate
    for (genvar g = 0; g < modem_ctl_pkg::REG_COUNT; g++)
    begin : g_reg
      always_comb
      begin
        regs_d[g] = (wr_en && (addr_q == 6'(g))) ? wr_data : regs_q[g];
      end
      always_ff @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          regs_q[g] <= reset_word(g);
        else
          regs_q[g] <= regs_d[g];
      end
    end
  endgenerate

  assign modem_clock_output_sel    = regs_q[modem_ctl_pkg::REG_MODEM_CLOCK_OUTPUT_TRIM][modem_ctl_pkg::MODEM_CLOCK_OUTPUT_SEL_MSB:modem_ctl_pkg::MODEM_CLOCK_OUTPUT_SEL_LSB];
  assign modem_clock_output_period = modem_ctl_pkg::MODEM_CLOCK_OUTPUT_PERIOD_ONE << modem_clock_output_sel;
  assign cmd_fire    = frame_end & pend_q;
  assign timer_hit   = regs_q[modem_ctl_pkg::REG_MODE_CTL][modem_ctl_pkg::MODE_TIMER_EN_BIT] &&
                       (doze_cnt_q == regs_q[modem_ctl_pkg::REG_DOZE_CMP]);

  // power mode sequencer with a shared down-counter for transition times
  always_comb
  begin
    state_d    = state_q;
    wait_d     = (wait_q != '0) ? modem_ctl_pkg::WAIT_W'(wait_q - 1'b1) : wait_q;
    doze_cnt_d = doze_cnt_q;
    case (state_q)
      modem_ctl_pkg::ST_OFF:
        if (wait_q == '0) state_d = modem_ctl_pkg::ST_IDLE;
      modem_ctl_pkg::ST_IDLE:
        if (cmd_fire)
        begin
          case (pend_req_q)
            modem_ctl_pkg::REQ_HIBERNATE: state_d = modem_ctl_pkg::ST_HIBERNATE;
            modem_ctl_pkg::REQ_DOZE:
            begin
              state_d    = modem_ctl_pkg::ST_DOZE;
              doze_cnt_d = '0;
            end
            modem_ctl_pkg::REQ_RECEIVE:
            begin
              state_d = modem_ctl_pkg::ST_RX_WARM;
              wait_d  = WAIT_WARM;
            end
            modem_ctl_pkg::REQ_TRANSMIT:
            begin
              state_d = modem_ctl_pkg::ST_TX_WARM;
              wait_d  = WAIT_WARM;
            end
            default: state_d = modem_ctl_pkg::ST_IDLE;
          endcase
        end
      modem_ctl_pkg::ST_HIBERNATE:
        if (!attention_wake_n_i)
        begin
          state_d = modem_ctl_pkg::ST_HIB_WAKE;
          wait_d  = WAIT_HIB;
        end
      modem_ctl_pkg::ST_DOZE:
      begin
        doze_cnt_d = 16'(doze_cnt_q + 16'h0001);
        if (!attention_wake_n_i || timer_hit)
        begin
          state_d = modem_ctl_pkg::ST_DOZE_WAKE;
          wait_d  = modem_ctl_pkg::WAIT_W'(WAIT_DOZE + modem_clock_output_period);
        end
      end
      modem_ctl_pkg::ST_HIB_WAKE, modem_ctl_pkg::ST_DOZE_WAKE:
        if (wait_q == '0) state_d = modem_ctl_pkg::ST_IDLE;
      modem_ctl_pkg::ST_RX_WARM:
        if (wait_q == '0) state_d = modem_ctl_pkg::ST_RX;
      modem_ctl_pkg::ST_TX_WARM:
        if (wait_q == '0) state_d = modem_ctl_pkg::ST_TX;
      modem_ctl_pkg::ST_RX, modem_ctl_pkg::ST_TX:
        if (cmd_fire && (pend_req_q == modem_ctl_pkg::REQ_IDLE)) state_d = modem_ctl_pkg::ST_IDLE;
      default: state_d = modem_ctl_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q    <= modem_ctl_pkg::ST_OFF;
      wait_q     <= WAIT_OFF;
      doze_cnt_q <= '0;
    end
    else
    begin
      state_q    <= state_d;
      wait_q     <= wait_d;
      doze_cnt_q <= doze_cnt_d;
    end
  end

  // oscillator stops in off and hibernate, including the restart wait
  assign osc_on   = (state_q != modem_ctl_pkg::ST_OFF) && (state_q != modem_ctl_pkg::ST_HIBERNATE) &&
                    (state_q != modem_ctl_pkg::ST_HIB_WAKE);
  assign modem_clock_output_run = osc_on && ((state_q != modem_ctl_pkg::ST_DOZE) ||
                    (regs_q[modem_ctl_pkg::REG_PIN_CFG][modem_ctl_pkg::PIN_CFG_DOZE_MODEM_CLOCK_OUTPUT_BIT] &&
                     (modem_clock_output_sel >= modem_ctl_pkg::MODEM_CLOCK_OUTPUT_DOZE_MIN_SEL)));
  // select 000 is the fastest toggle the core clock allows
  assign modem_clock_output_half = 8'((modem_ctl_pkg::MODEM_CLOCK_OUTPUT_DIV_ONE << modem_clock_output_sel) - 8'h01);

  // pin drivers, all registered; tristate while held in off
  always_comb
  begin
    div_d  = '0;
    modem_clock_output_d = 1'b0;
    if (modem_clock_output_run)
    begin
      if (div_q >= modem_clock_output_half)
        modem_clock_output_d = ~modem_clock_output_q;
      else
      begin
        div_d  = 8'(div_q + 8'h01);
        modem_clock_output_d = modem_clock_output_q;
      end
    end
    modem_clock_output_oe_d = (state_q != modem_ctl_pkg::ST_OFF);
    irq_oe_d  = (state_q != modem_ctl_pkg::ST_OFF);
    miso_d    = frame ? sh_miso : 1'b0;
    if (state_q == modem_ctl_pkg::ST_OFF)
      miso_oe_d = 1'b0;
    else if (frame)
      miso_oe_d = 1'b1;
    else
      miso_oe_d = ~regs_q[modem_ctl_pkg::REG_PIN_CFG][modem_ctl_pkg::PIN_CFG_MISO_FLOAT_BIT];
    osc_d   = osc_on;
    rx_on_d = (state_q == modem_ctl_pkg::ST_RX);
    tx_on_d = (state_q == modem_ctl_pkg::ST_TX);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q     <= '0;
      modem_clock_output_q    <= 1'b0;
      modem_clock_output_oe_q <= 1'b0;
      irq_oe_q  <= 1'b0;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
      osc_q     <= 1'b0;
      rx_on_q   <= 1'b0;
      tx_on_q   <= 1'b0;
    end
    else
    begin
      div_q     <= div_d;
      modem_clock_output_q    <= modem_clock_output_d;
      modem_clock_output_oe_q <= modem_clock_output_oe_d;
      irq_oe_q  <= irq_oe_d;
      miso_q    <= miso_d;
      miso_oe_q <= miso_oe_d;
      osc_q     <= osc_d;
      rx_on_q   <= rx_on_d;
      tx_on_q   <= tx_on_d;
    end
  end

  assign miso_o                  = miso_q;
  assign miso_oe_o               = miso_oe_q;
  assign irq_n_o                 = 1'b1; // no interrupt sources in this block
  assign irq_oe_o                = irq_oe_q;
  assign modem_clock_output_o    = modem_clock_output_q;
  assign modem_clock_output_oe_o = modem_clock_output_oe_q;
  assign osc_enable_o            = osc_q;
  assign xtal_trim_o             = regs_q[modem_ctl_pkg::REG_MODEM_CLOCK_OUTPUT_TRIM][modem_ctl_pkg::TRIM_MSB:modem_ctl_pkg::TRIM_LSB];
  assign receiver_on_o           = rx_on_q;
  assign transmitter_on_o        = tx_on_q;

endmodule : modem_ctl

// File: tb/modem_ctl_monitor.sv
`timescale 1ns/1ps
module modem_ctl_monitor (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  // watched ports
  input wire logic       serial_shift_clock_i,
  input wire logic       ce_n_i,
  input wire logic       miso_o,
  input wire logic       miso_oe_o,
  input wire logic       irq_oe_o,
  input wire logic       modem_clock_output_o,
  input wire logic       modem_clock_output_oe_o,
  input wire logic       osc_enable_o,
  input wire logic [7:0] xtal_trim_o,
  input wire logic       receiver_on_o,
  input wire logic       transmitter_on_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // everything floated while in off
  sequence s_off_float;
    !irq_oe_o && !modem_clock_output_oe_o && !miso_oe_o;
  endsequence
  sequence s_deselected;
    ce_n_i [*4];
  endsequence
  a_off_float: assert property ($rose(rst_n_i) |-> s_off_float [*8])
    else $error("output driven during off");
  a_idle_drive: assert property ($rose(irq_oe_o) |-> (modem_clock_output_oe_o && osc_enable_o) ##1 $changed(modem_clock_output_o))
    else $error("clock output not driven in idle");
  a_radio_excl: assert property (!(receiver_on_o && transmitter_on_o))
    else $error("receiver and transmitter both on");
  a_rx_after_frame: assert property ($rose(receiver_on_o) |-> $past(ce_n_i, 4))
    else $error("receiver on before frame end");
  // trim only moves from a serial write, never outside a frame
  a_trim_framed: assert property ($changed(xtal_trim_o) |-> !$past(ce_n_i))
    else $error("trim changed outside a frame");
  a_miso_hold: assert property (!ce_n_i && serial_shift_clock_i && $past(serial_shift_clock_i) |-> $stable(miso_o))
    else $error("miso moved while clock high");
  a_miso_idle: assert property (s_deselected |-> !miso_o)
    else $error("miso not low when deselected");
  a_clk_stopped: assert property (!osc_enable_o [*2] |-> !modem_clock_output_o)
    else $error("clock output runs with oscillator off");
endmodule : modem_ctl_monitor

// File: tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model #(
  parameter int HALF = 4
) (
  // core clock
  input  wire logic clk_i,
  // serial pins
  output logic      sclk_o,
  output logic      ce_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  logic last;
  // idle bus: clock parked low, deselected
  initial
  begin
    sclk_o = 1'b0;
    ce_n_o = 1'b1;
    mosi_o = 1'b0;
    last   = 1'b0;
  end
  // header then one word; HALF core cycles per half keeps the clock under 8 MHz
  task automatic xfer(input logic [7:0] hdr, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {hdr, wd};
    rd = 16'h0000;
    @(posedge clk_i);
    ce_n_o <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      mosi_o <= sh[i];
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b1;
      last = miso_oe_i ? miso_i : ~last; // a floating line reads as the inverse of the last bit
      if (i < 16) rd[i] = last;
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge clk_i);
    ce_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : xfer
endmodule : spi_host_model

// File: tb/modem_ctl_bench.sv
`timescale 1ns/1ps
module modem_ctl_bench;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        att_n = 1'b1;
  logic        sclk, ce_n, mosi, miso, miso_oe, irq_n, irq_oe, modem_clock_output, modem_clock_output_oe, osc_en, rx_on, tx_on, c;
  logic [7:0]  trim;
  logic [15:0] rd;
  int          n_errors = 0;
  int          n_compared = 0;
  always #10 mclk_i = ~mclk_i;
  // short transition counts keep the run brief
  modem_ctl #(.OFF_IDLE_CYC(20), .HIB_IDLE_CYC(16), .DOZE_IDLE_CYC(10), .RXTX_WARM_CYC(8)) u_modem_ctl (
    .mclk_i, .rst_n_i, .serial_shift_clock_i(sclk), .ce_n_i(ce_n), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_o(miso_oe), .attention_wake_n_i(att_n), .irq_n_o(irq_n), .irq_oe_o(irq_oe),
    .modem_clock_output_o(modem_clock_output), .modem_clock_output_oe_o(modem_clock_output_oe), .osc_enable_o(osc_en),
    .xtal_trim_o(trim), .receiver_on_o(rx_on), .transmitter_on_o(tx_on));
  spi_host_model #(.HALF(4)) host (.clk_i(mclk_i), .sclk_o(sclk), .ce_n_o(ce_n), .mosi_o(mosi),
    .miso_i(miso), .miso_oe_i(miso_oe));
  task automatic stop_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic pick(input int s);
    case (s)
      0: return irq_oe;
      1: return rx_on;
      2: return tx_on;
      default: return osc_en;
    endcase
  endfunction : pick
  // bounded wait on a status pin
  task automatic wait_lvl(input int s, input logic lvl, input int n);
    for (int k = 0; k < n && pick(s) !== lvl; k++)
      @(posedge mclk_i);
    chk("wait", lvl, pick(s));
    if (pick(s) !== lvl)
      stop_test();
  endtask : wait_lvl
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host.xfer({2'b00, a}, d, rd);
  endtask : wr
  task automatic rdr(input logic [5:0] a);
    host.xfer({2'b10, a}, 16'h0000, rd);
  endtask : rdr
  task automatic t_reset();
    repeat (4) @(posedge mclk_i);
    chk("irq_oe", 1'b0, irq_oe);
    rst_n_i <= 1'b1;
    wait_lvl(0, 1'b1, 40);
    chk("modem_clock_output_oe", 1'b1, modem_clock_output_oe);
    chk("irq_n", 1'b1, irq_n);
  endtask : t_reset
  task automatic t_regs();
    wr(6'h0A, 16'hA500);
    chk("trim", 16'h00A5, trim);
    rdr(6'h0A);
    chk("rd 0A", 16'hA500, rd);
    @(posedge mclk_i);
    c = modem_clock_output;
    @(posedge mclk_i);
    chk("modem_clock_output", !c, modem_clock_output);
  endtask : t_regs
  task automatic t_float();
    chk("miso_oe", 1'b0, miso_oe);
    wr(6'h07, 16'h0000);
    chk("miso_oe", 1'b1, miso_oe);
    chk("miso", 1'b0, miso);
    wr(6'h07, 16'h0800);
  endtask : t_float
  task automatic t_modes();
    for (int m = 3; m <= 4; m++)
    begin
      wr(6'h02, 16'(m));
      wait_lvl(m - 2, 1'b1, 30);
      rdr(6'h01);
      chk("state", 16'(m * 2 + 1), rd & 16'h000F);
      wr(6'h02, 16'h0000);
      wait_lvl(m - 2, 1'b0, 30);
    end
  endtask : t_modes
  task automatic t_doze();
    wr(6'h03, 16'h0020);
    wr(6'h02, 16'h0102);
    repeat (4) @(posedge mclk_i);
    chk("osc", 1'b1, osc_en);
    chk("modem_clock_output", 1'b0, modem_clock_output);
    repeat (60) @(posedge mclk_i);
    rdr(6'h01);
    chk("state", 16'h0005, rd & 16'h000F);
    // slow clock out kept alive in doze, then an attention wake
    wr(6'h07, 16'h0A00);
    wr(6'h0A, 16'hA505);
    wr(6'h02, 16'h0002);
    repeat (4) @(posedge mclk_i);
    c = modem_clock_output;
    repeat (32) @(posedge mclk_i);
    chk("doze modem_clock_output", !c, modem_clock_output);
    att_n <= 1'b0;
    repeat (120) @(posedge mclk_i);
    att_n <= 1'b1;
    rdr(6'h01);
    chk("state", 16'h0005, rd & 16'h000F);
    wr(6'h0A, 16'hA500);
    wr(6'h07, 16'h0800);
  endtask : t_doze
  task automatic t_hib();
    wr(6'h02, 16'h0001);
    wait_lvl(3, 1'b0, 20);
    wr(6'h0A, 16'h3300);
    att_n <= 1'b0;
    wait_lvl(3, 1'b1, 40);
    att_n <= 1'b1;
    repeat (20) @(posedge mclk_i);
    rdr(6'h0A);
    chk("rd 0A", 16'hA500, rd);
  endtask : t_hib
  initial
  begin
    t_reset();
    t_regs();
    t_float();
    t_modes();
    t_doze();
    t_hib();
    stop_test();
  end
endmodule : modem_ctl_bench
bind modem_ctl modem_ctl_monitor u_modem_ctl_monitor (.mclk_i, .rst_n_i, .serial_shift_clock_i, .ce_n_i,
  .miso_o, .miso_oe_o, .irq_oe_o, .modem_clock_output_o, .modem_clock_output_oe_o, .osc_enable_o,
  .xtal_trim_o, .receiver_on_o, .transmitter_on_o);
